// ===== logic/dpac_access_ctrl.sv
// debug, programming and test port access control
`timescale 1ns/100ps
`default_nettype none
`include "dpac_consts.svh"
// What this block does
// - Three external debug paths exist: the scan port, the two-wire debug port and trace output.
// - Both ports reach programming and debug, and only the scan port reaches scan chains.
// - On-chip debug logic leaves reset disabled and only firmware can enable it.
// - Nothing outside firmware can set debug enable; a full erase clears it.
// - An active security lock shuts every programming, debug and test path for good.
// - Pins used are 0 when off, 4 or 5 for scan, 2 for two-wire, 1 for trace, 3 for both.
// - The scan port has four pins plus an optional test reset pin.
// - A fresh device starts with the scan pins on, and configuration can free them to GPIO.
// - A scan register write resets the device unless port select disables the ports.
// - By default the port runs 4-wire scan with mode-select as input only.
// - In two-wire port select the mode-select pin is bidirectional for two-wire acquire.
// - After switching from two-wire to scan the mode-select pin is input only again.
// - The shared pin is the external reset only on the variant without a dedicated one.
// - Two-wire mode opens by port select, firmware request, or the acquire sequence on a pin pair inside the key window.
module dpac_access_ctrl #(
  parameter logic [`DPAC_ACQ_LEN-1:0] ACQ_KEY = 16'h6A93
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [`DPAC_ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [1:0] nvl_port_select_in,
  input wire logic secure_lock_in,
  input wire logic no_dedicated_reset_in,
  input wire logic full_erase_in,
  input wire logic tck_in,
  input wire logic tms_in,
  output logic tms_out,
  output logic tms_oe_n_out,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  input wire logic trst_n_in,
  input wire logic usb_dp_in,
  input wire logic usb_dm_in,
  output logic usb_dm_out,
  output logic usb_dm_oe_n_out,
  input wire logic swd_dout_in,
  input wire logic swd_drive_in,
  input wire logic swv_bit_in,
  output logic swd_clk_rise_out,
  output logic swd_din_out,
  output logic debug_enable_out,
  output logic ext_access_out,
  output logic scan_access_out,
  output logic [2:0] gpio_used_out,
  output logic shared_pin_reset_out,
  output logic device_reset_out
);
  localparam logic [`DPAC_KEY_CNT_W-1:0] KEY_CYC = `DPAC_KEY_CNT_W'(`DPAC_KEY_CYCLES);
  localparam logic [`DPAC_GAP_CNT_W-1:0] GAP_MIN = `DPAC_GAP_CNT_W'(`DPAC_TCK_MIN_CYC - 1);
  localparam int I_TCK = 0;
  localparam int I_TMS = 1;
  localparam int I_TDI = 2;
  localparam int I_TRST = 3;
  localparam int I_DP = 4;
  localparam int I_DM = 5;

  // ************************************************************
  // pin sampling and straps
  // ************************************************************
  logic [5:0] pin_lvl;
  logic [5:0] pin_rise;
  logic [5:0] pin_fall;
  logic init_q;
  logic locked_q;
  logic noreset_q;
  logic [1:0] nvl_q;

  dpac_pin_sync #(.WIDTH(6)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pins_in({usb_dm_in, usb_dp_in, trst_n_in, tdi_in, tms_in, tck_in}),
    .level_out(pin_lvl),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  // latched settings are caught once after release
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      init_q <= 1'b0;
      locked_q <= 1'b0;
      noreset_q <= 1'b0;
      nvl_q <= `DPAC_DPS_JTAG4;
    end else if (!init_q) begin
      init_q <= 1'b1;
      locked_q <= secure_lock_in;
      noreset_q <= no_dedicated_reset_in;
      nvl_q <= nvl_port_select_in;
    end
  end

  assign shared_pin_reset_out = noreset_q;

  // ************************************************************
  // register bus
  // ************************************************************
  logic debug_en_q;
  logic swv_en_q;
  logic tck_fast_q;
  logic ctrl_wr;
  logic stat_wr;
  logic fw_dbg_set;
  logic [1:0] port_req;
  logic [31:0] rdata_q;
  dpac_pkg::dpac_mode_type mode_q;
  logic swd_usb_q;
  logic win_q;
  logic swv_active;

  assign ctrl_wr = reg_write_in && (reg_addr_in == `DPAC_ADDR_CTRL);
  assign stat_wr = reg_write_in && (reg_addr_in == `DPAC_ADDR_STATUS);
  assign fw_dbg_set = ctrl_wr && reg_wdata_in[`DPAC_CTRL_DBG_EN];
  assign port_req = ctrl_wr ? reg_wdata_in[`DPAC_CTRL_REQ_HI:`DPAC_CTRL_REQ_LO] : `DPAC_REQ_KEEP;

  // only the firmware write sets debug enable; no pin path reaches it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      debug_en_q <= 1'b0;
      swv_en_q <= 1'b0;
    end else if (full_erase_in) begin
      debug_en_q <= 1'b0;
      swv_en_q <= 1'b0;
    end else if (ctrl_wr) begin
      debug_en_q <= reg_wdata_in[`DPAC_CTRL_DBG_EN];
      swv_en_q <= reg_wdata_in[`DPAC_CTRL_SWV_EN];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_read_in && reg_addr_in == `DPAC_ADDR_CTRL) begin
      rdata_q <= {27'h000_0000, swv_en_q, 3'h0, debug_en_q};
    end else if (reg_read_in && reg_addr_in == `DPAC_ADDR_STATUS) begin
      rdata_q <= {20'h0_0000, win_q, swd_usb_q, noreset_q, tck_fast_q, gpio_used_out,
                  locked_q, swv_active, mode_q, debug_enable_out};
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata_out = rdata_q;

  // ************************************************************
  // key window and acquire sequence
  // ************************************************************
  logic [`DPAC_KEY_CNT_W-1:0] win_cnt_q;
  logic [1:0] acq_hit;
  logic [1:0] pair_rise;
  logic [1:0] pair_data;

  assign pair_rise = {pin_rise[I_DP], pin_rise[I_TCK]};
  assign pair_data = {pin_lvl[I_DM], pin_lvl[I_TMS]};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      win_cnt_q <= '0;
    end else if (win_cnt_q != KEY_CYC) begin
      win_cnt_q <= win_cnt_q + `DPAC_KEY_CNT_W'(1);
    end
  end

  assign win_q = (win_cnt_q != KEY_CYC);

  generate
    for (genvar g = 0; g < 2; g++) begin : g_pair
      logic [`DPAC_ACQ_LEN-1:0] sh_q;
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          sh_q <= '0;
        end else if (acq_hit[g]) begin
          sh_q <= '0;
        end else if (win_q && pair_rise[g]) begin
          sh_q <= {sh_q[`DPAC_ACQ_LEN-2:0], pair_data[g]};
        end
      end
      assign acq_hit[g] = win_q && (sh_q == ACQ_KEY);
    end
  endgenerate

  // ************************************************************
  // port mode
  // ************************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= dpac_pkg::mode_off;
      swd_usb_q <= 1'b0;
    end else if (!init_q) begin
      if (secure_lock_in || nvl_port_select_in == `DPAC_DPS_OFF) begin
        mode_q <= dpac_pkg::mode_off;
      end else if (nvl_port_select_in == `DPAC_DPS_SWD) begin
        mode_q <= dpac_pkg::mode_swd;
      end else begin
        mode_q <= dpac_pkg::mode_jtag;
      end
    end else if (locked_q) begin
      mode_q <= dpac_pkg::mode_off;
    end else if (acq_hit[1]) begin
      mode_q <= dpac_pkg::mode_swd;
      swd_usb_q <= 1'b1;
    end else if (acq_hit[0]) begin
      mode_q <= dpac_pkg::mode_swd;
      swd_usb_q <= 1'b0;
    end else if (port_req == `DPAC_REQ_JTAG) begin
      mode_q <= dpac_pkg::mode_jtag;
      swd_usb_q <= 1'b0;
    end else if (port_req == `DPAC_REQ_SWD) begin
      mode_q <= dpac_pkg::mode_swd;
    end else if (port_req == `DPAC_REQ_OFF) begin
      mode_q <= dpac_pkg::mode_off;
    end
  end

  assign ext_access_out = (mode_q != dpac_pkg::mode_off);
  assign scan_access_out = (mode_q == dpac_pkg::mode_jtag);
  assign debug_enable_out = debug_en_q && !locked_q;
  assign swv_active = swv_en_q && debug_enable_out && (mode_q != dpac_pkg::mode_jtag);

  always_comb begin
    case (mode_q)
      dpac_pkg::mode_jtag: gpio_used_out = (nvl_q == `DPAC_DPS_JTAG5) ?
                                           `DPAC_PINS_JTAG5 : `DPAC_PINS_JTAG4;
      dpac_pkg::mode_swd: gpio_used_out = swv_active ? `DPAC_PINS_SWD_SWV : `DPAC_PINS_SWD;
      default: gpio_used_out = swv_active ? `DPAC_PINS_SWV : `DPAC_PINS_NONE;
    endcase
  end

  // ************************************************************
  // test access controller
  // ************************************************************
  function automatic dpac_pkg::dpac_tap_type tap_next(input dpac_pkg::dpac_tap_type s,
                                                      input logic m);
    case (s)
      dpac_pkg::tap_tlr: tap_next = m ? dpac_pkg::tap_tlr : dpac_pkg::tap_idle;
      dpac_pkg::tap_idle: tap_next = m ? dpac_pkg::tap_sel_dr : dpac_pkg::tap_idle;
      dpac_pkg::tap_sel_dr: tap_next = m ? dpac_pkg::tap_sel_ir : dpac_pkg::tap_cap_dr;
      dpac_pkg::tap_cap_dr: tap_next = m ? dpac_pkg::tap_ex1_dr : dpac_pkg::tap_sh_dr;
      dpac_pkg::tap_sh_dr: tap_next = m ? dpac_pkg::tap_ex1_dr : dpac_pkg::tap_sh_dr;
      dpac_pkg::tap_ex1_dr: tap_next = m ? dpac_pkg::tap_upd_dr : dpac_pkg::tap_pau_dr;
      dpac_pkg::tap_pau_dr: tap_next = m ? dpac_pkg::tap_ex2_dr : dpac_pkg::tap_pau_dr;
      dpac_pkg::tap_ex2_dr: tap_next = m ? dpac_pkg::tap_upd_dr : dpac_pkg::tap_sh_dr;
      dpac_pkg::tap_sel_ir: tap_next = m ? dpac_pkg::tap_tlr : dpac_pkg::tap_cap_ir;
      dpac_pkg::tap_cap_ir: tap_next = m ? dpac_pkg::tap_ex1_ir : dpac_pkg::tap_sh_ir;
      dpac_pkg::tap_sh_ir: tap_next = m ? dpac_pkg::tap_ex1_ir : dpac_pkg::tap_sh_ir;
      dpac_pkg::tap_ex1_ir: tap_next = m ? dpac_pkg::tap_upd_ir : dpac_pkg::tap_pau_ir;
      dpac_pkg::tap_pau_ir: tap_next = m ? dpac_pkg::tap_ex2_ir : dpac_pkg::tap_pau_ir;
      dpac_pkg::tap_ex2_ir: tap_next = m ? dpac_pkg::tap_upd_ir : dpac_pkg::tap_sh_ir;
      default: tap_next = m ? dpac_pkg::tap_sel_dr : dpac_pkg::tap_idle;
    endcase
  endfunction

  dpac_pkg::dpac_tap_type tap_q;
  logic [`DPAC_IR_W-1:0] ir_sh_q;
  logic [`DPAC_IR_W-1:0] ir_q;
  logic dr_sh_q;
  logic tap_reset;
  logic tck_rise;
  logic dev_rst_q;

  // test reset is honoured only in 5-wire select
  assign tap_reset = (mode_q != dpac_pkg::mode_jtag) ||
                     (nvl_q == `DPAC_DPS_JTAG5 && !pin_lvl[I_TRST]);
  assign tck_rise = pin_rise[I_TCK];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tap_q <= dpac_pkg::tap_tlr;
    end else if (tap_reset) begin
      tap_q <= dpac_pkg::tap_tlr;
    end else if (tck_rise) begin
      tap_q <= tap_next(tap_q, pin_lvl[I_TMS]);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ir_sh_q <= `DPAC_IR_BYPASS;
      ir_q <= `DPAC_IR_BYPASS;
      dr_sh_q <= 1'b0;
    end else if (tap_q == dpac_pkg::tap_tlr) begin
      ir_q <= `DPAC_IR_BYPASS;
    end else if (tck_rise) begin
      case (tap_q)
        dpac_pkg::tap_cap_ir: ir_sh_q <= `DPAC_IR_W'(1);
        dpac_pkg::tap_sh_ir: ir_sh_q <= {pin_lvl[I_TDI], ir_sh_q[`DPAC_IR_W-1:1]};
        dpac_pkg::tap_upd_ir: ir_q <= ir_sh_q;
        dpac_pkg::tap_cap_dr: dr_sh_q <= 1'b0;
        dpac_pkg::tap_sh_dr: dr_sh_q <= pin_lvl[I_TDI];
        default: dr_sh_q <= dr_sh_q;
      endcase
    end
  end

  // device reset from the scan register, refused when ports are disabled
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dev_rst_q <= 1'b0;
    end else begin
      dev_rst_q <= tck_rise && tap_q == dpac_pkg::tap_upd_dr && ir_q == `DPAC_IR_RESET &&
                   dr_sh_q && nvl_q != `DPAC_DPS_OFF && !locked_q;
    end
  end

  assign device_reset_out = dev_rst_q;

  // ************************************************************
  // pin drive
  // ************************************************************
  logic tdo_q;
  logic tdo_shift;
  logic tms_q;
  logic dm_q;
  logic swclk_q;
  logic swdin_q;

  assign tdo_shift = (tap_q == dpac_pkg::tap_sh_dr) || (tap_q == dpac_pkg::tap_sh_ir);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tdo_q <= 1'b0;
      tms_q <= 1'b0;
      dm_q <= 1'b0;
      swclk_q <= 1'b0;
      swdin_q <= 1'b0;
    end else begin
      if (swv_active) begin
        tdo_q <= swv_bit_in;
      end else if (pin_fall[I_TCK]) begin
        tdo_q <= (tap_q == dpac_pkg::tap_sh_ir) ? ir_sh_q[0] : dr_sh_q;
      end
      tms_q <= swd_dout_in;
      dm_q <= swd_dout_in;
      swclk_q <= (mode_q == dpac_pkg::mode_swd) && pair_rise[swd_usb_q];
      swdin_q <= pair_data[swd_usb_q];
    end
  end

  assign tdo_out = tdo_q;
  assign tdo_oe_n_out = !((scan_access_out && tdo_shift) || swv_active);
  assign tms_out = tms_q;
  assign tms_oe_n_out = !(mode_q == dpac_pkg::mode_swd && !swd_usb_q && swd_drive_in);
  assign usb_dm_out = dm_q;
  assign usb_dm_oe_n_out = !(mode_q == dpac_pkg::mode_swd && swd_usb_q && swd_drive_in);
  assign swd_clk_rise_out = swclk_q;
  assign swd_din_out = swdin_q;

  // ************************************************************
  // test clock rate monitor
  // ************************************************************
  logic [`DPAC_GAP_CNT_W-1:0] gap_q;
  logic seen_q;
  logic fast_evt;

  assign fast_evt = tck_rise && seen_q && scan_access_out && (gap_q < GAP_MIN);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gap_q <= '0;
      seen_q <= 1'b0;
      tck_fast_q <= 1'b0;
    end else begin
      if (tck_rise) begin
        gap_q <= '0;
        seen_q <= 1'b1;
      end else if (gap_q != '1) begin
        gap_q <= gap_q + `DPAC_GAP_CNT_W'(1);
      end
      if (fast_evt) begin
        tck_fast_q <= 1'b1;
      end else if (stat_wr && reg_wdata_in[`DPAC_STAT_TCK_FAST]) begin
        tck_fast_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_usb_hit;
    init_q && !locked_q && acq_hit[1];
  endsequence
  sequence s_off_req;
    init_q && !locked_q && acq_hit == 2'h0 && port_req == `DPAC_REQ_OFF;
  endsequence

  property p_lock_shut;
    init_q && locked_q |=> mode_q == dpac_pkg::mode_off && !debug_enable_out && !ext_access_out;
  endproperty
  a_lock_shut: assert property (p_lock_shut) else $error("lock left a port open");
  property p_fw_only;
    $rose(debug_en_q) |-> $past(fw_dbg_set);
  endproperty
  a_fw_only: assert property (p_fw_only) else $error("debug enabled without firmware");
  property p_pins_swd;
    mode_q == dpac_pkg::mode_swd && !swv_active |-> gpio_used_out == 3'h2;
  endproperty
  a_pins_swd: assert property (p_pins_swd) else $error("wrong pin count for two-wire");
  property p_tms_input;
    mode_q == dpac_pkg::mode_jtag |-> tms_oe_n_out && usb_dm_oe_n_out;
  endproperty
  a_tms_input: assert property (p_tms_input) else $error("mode-select driven in scan");
  property p_scan_only;
    !scan_access_out |=> tap_q == dpac_pkg::tap_tlr;
  endproperty
  a_scan_only: assert property (p_scan_only) else $error("scan chain open outside scan mode");
  property p_rst_gate;
    device_reset_out |-> nvl_q != `DPAC_DPS_OFF && $past(tap_q) == dpac_pkg::tap_upd_dr ##1
                         !device_reset_out;
  endproperty
  a_rst_gate: assert property (p_rst_gate) else $error("device reset not gated");
  property p_usb_acq;
    s_usb_hit |=> mode_q == dpac_pkg::mode_swd && swd_usb_q;
  endproperty
  a_usb_acq: assert property (p_usb_acq) else $error("acquire did not open two-wire");
  property p_window_len;
    $fell(win_q) |-> win_cnt_q == 9'h140 && $past(win_cnt_q) == 9'h13F;
  endproperty
  a_window_len: assert property (p_window_len) else $error("key window length wrong");
  property p_no_late_acq;
    !win_q |-> acq_hit == 2'h0 ##1 !win_q;
  endproperty
  a_no_late_acq: assert property (p_no_late_acq) else $error("acquire after key window");
  property p_port_off;
    s_off_req |=> mode_q == dpac_pkg::mode_off ##0 gpio_used_out != 3'h4;
  endproperty
  a_port_off: assert property (p_port_off) else $error("port not released to GPIO");
  property p_default_jtag;
    !init_q && !secure_lock_in && nvl_port_select_in == `DPAC_DPS_JTAG4 |=>
      mode_q == dpac_pkg::mode_jtag && gpio_used_out == 3'h4 && tms_oe_n_out;
  endproperty
  a_default_jtag: assert property (p_default_jtag) else $error("default not 4-wire scan");
  property p_fast_flag;
    fast_evt |=> tck_fast_q [*2];
  endproperty
  a_fast_flag: assert property (p_fast_flag) else $error("fast clock flag lost");
endmodule
`default_nettype wire

// ===== logic/dpac_consts.svh
// constants for the debug port access control block
`ifndef DPAC_CONSTS_SVH
`define DPAC_CONSTS_SVH

// ************************************************************
// timing
// ************************************************************
`define DPAC_CLK_PERIOD_NS 25
`define DPAC_CLK_KHZ 40000
`define DPAC_KEY_WINDOW_NS 8000
`define DPAC_KEY_CYCLES (`DPAC_KEY_WINDOW_NS / `DPAC_CLK_PERIOD_NS)
`define DPAC_KEY_CNT_W 9
`define DPAC_TCK_MAX_KHZ 14000
`define DPAC_TCK_RATIO_NARROW 3
`define DPAC_TCK_RATIO_WIDE 5
`define DPAC_TCK_RATE_CYC ((`DPAC_CLK_KHZ + `DPAC_TCK_MAX_KHZ - 1) / `DPAC_TCK_MAX_KHZ)
`define DPAC_TCK_MIN_CYC \
  ((`DPAC_TCK_RATE_CYC > `DPAC_TCK_RATIO_NARROW) ? `DPAC_TCK_RATE_CYC : `DPAC_TCK_RATIO_NARROW)
`define DPAC_GAP_CNT_W 4

// ************************************************************
// register map
// ************************************************************
`define DPAC_ADDR_W 4
`define DPAC_ADDR_CTRL 4'h0
`define DPAC_ADDR_STATUS 4'h4
`define DPAC_CTRL_DBG_EN 0
`define DPAC_CTRL_REQ_LO 2
`define DPAC_CTRL_REQ_HI 3
`define DPAC_CTRL_SWV_EN 4
`define DPAC_STAT_TCK_FAST 8
`define DPAC_REQ_KEEP 2'h0
`define DPAC_REQ_JTAG 2'h1
`define DPAC_REQ_SWD 2'h2
`define DPAC_REQ_OFF 2'h3

// ************************************************************
// port select codes, pins, tap
// ************************************************************
`define DPAC_DPS_JTAG4 2'h0
`define DPAC_DPS_JTAG5 2'h1
`define DPAC_DPS_SWD 2'h2
`define DPAC_DPS_OFF 2'h3
`define DPAC_PINS_NONE 3'h0
`define DPAC_PINS_JTAG4 3'h4
`define DPAC_PINS_JTAG5 3'h5
`define DPAC_PINS_SWD 3'h2
`define DPAC_PINS_SWV 3'h1
`define DPAC_PINS_SWD_SWV 3'h3
`define DPAC_ACQ_LEN 16
`define DPAC_IR_W 4
`define DPAC_IR_RESET 4'h8
`define DPAC_IR_BYPASS 4'hF

`endif

// ===== logic/dpac_pin_sync.sv
// two-flop pin synchroniser with edge detection
`timescale 1ns/100ps
`default_nettype none
module dpac_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out,
  output logic [WIDTH-1:0] fall_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] last_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= pins_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out = sync_q & ~last_q;
  assign fall_out = ~sync_q & last_q;
endmodule
`default_nettype wire

// ===== logic/dpac_pkg.sv
// types for the debug port access control block
package dpac_pkg;
  typedef enum logic [1:0] {mode_off, mode_jtag, mode_swd} dpac_mode_type;
  typedef enum logic [3:0] {
    tap_tlr, tap_idle, tap_sel_dr, tap_cap_dr, tap_sh_dr, tap_ex1_dr, tap_pau_dr, tap_ex2_dr,
    tap_upd_dr, tap_sel_ir, tap_cap_ir, tap_sh_ir, tap_ex1_ir, tap_pau_ir, tap_ex2_ir, tap_upd_ir
  } dpac_tap_type;
endpackage

// ===== tb/dpac_host_model.sv
// behavioural host programmer that drives the debug pins
`timescale 1ns/100ps
`default_nettype none
module dpac_host_model (
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  output logic trst_n_out,
  output logic dp_out,
  output logic dm_out
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
    trst_n_out = 1'b1;
    dp_out = 1'b0;
    dm_out = 1'b1;
  end
  // one bit per 200 ns, clock idles low between frames
  task automatic send(input logic usb, input logic msb, input logic [31:0] d,
      input logic [31:0] t, input int n);
    int k;
    #7;
    for (int i = 0; i < n; i++) begin
      k = msb ? n - 1 - i : i;
      if (usb)
        dm_out = d[k];
      else
        tms_out = d[k];
      tdi_out = t[k];
      #100;
      if (usb)
        dp_out = 1'b1;
      else
        tck_out = 1'b1;
      #100;
      dp_out = 1'b0;
      tck_out = 1'b0;
    end
    tdi_out = ~tdi_out;
  endtask
  // two clock pulses on purpose too close together, to trip the rate monitor
  task automatic burst();
    repeat (2) begin
      #25 tck_out = 1'b1;
      #25 tck_out = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_dpac_access_ctrl.sv
// self-checking bench for the debug port access control block
`timescale 1ns/100ps
`default_nettype none
`include "dpac_consts.svh"
module tb_dpac_access_ctrl;
  localparam logic [15:0] KEY = 16'h6A93;
  logic clk_in = 1'b0, rst_in = 1'b1, reg_write_in = 1'b0, reg_read_in = 1'b0;
  logic secure_lock_in = 1'b0, no_dedicated_reset_in = 1'b0, full_erase_in = 1'b0;
  logic swd_dout_in = 1'b0, swd_drive_in = 1'b0, swv_bit_in = 1'b0, h_tms, h_dm;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, seed = 32'h42, r = 32'h0;
  logic [1:0] nvl_port_select_in = 2'h0;
  logic tms_out, tms_oe_n_out, tdo_out, tdo_oe_n_out, usb_dm_out, usb_dm_oe_n_out;
  logic swd_clk_rise_out, swd_din_out, debug_enable_out, ext_access_out, scan_access_out;
  logic shared_pin_reset_out, device_reset_out;
  logic [2:0] gpio_used_out;
  wire logic tck_in, tdi_in, trst_n_in, usb_dp_in;
  wire logic tms_in = tms_oe_n_out ? h_tms : tms_out;
  wire logic usb_dm_in = usb_dm_oe_n_out ? h_dm : usb_dm_out;
  int n_fail = 0, num_checks = 0, pulses = 0, sw_rises = 0;
  logic [1:0] prev = 2'h0;
  dpac_access_ctrl #(.ACQ_KEY(KEY)) u_dpac_access_ctrl (.*);
  dpac_host_model u_dpac_host_model (.tck_out(tck_in), .tms_out(h_tms), .tdi_out(tdi_in),
    .trst_n_out(trst_n_in), .dp_out(usb_dp_in), .dm_out(h_dm));
  always #12.5 clk_in = ~clk_in;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  always @(posedge clk_in) begin
    r <= rnd();
    swd_dout_in <= r[0];
    swv_bit_in <= r[1];
    prev <= {swd_dout_in, swv_bit_in};
    if (device_reset_out === 1'b1)
      pulses++;
    if (swd_clk_rise_out === 1'b1)
      sw_rises++;
  end
  function automatic logic [2:0] pins(input logic [1:0] n);
    case (n)
      2'h0: return `DPAC_PINS_JTAG4;
      2'h1: return `DPAC_PINS_JTAG5;
      2'h2: return `DPAC_PINS_SWD;
      default: return `DPAC_PINS_NONE;
    endcase
  endfunction
  task automatic conclude();
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_write_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_read_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic boot(input logic [1:0] n, input logic lk);
    @(posedge clk_in);
    rst_in <= 1'b1;
    nvl_port_select_in <= n;
    secure_lock_in <= lk;
    no_dedicated_reset_in <= n[0];
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    tick(3);
    pulses = 0;
    sw_rises = 0;
  endtask
  // tap reset by five high mode-select rises, then load reset register and shift a one
  task automatic tap_reset();
    u_dpac_host_model.send(1'b0, 1'b0, 32'h000CE0DF, 32'h00042000, 21);
    tick(8);
  endtask
  initial begin
    logic [31:0] d;
    logic [3:0] a;
    swd_drive_in <= 1'b1;
    for (int n = 0; n < 4; n++) begin
      boot(n[1:0], 1'b0);
      chk(gpio_used_out, pins(n[1:0]));
      chk(tms_oe_n_out, n != 2);
      chk(scan_access_out, n < 2);
      chk(shared_pin_reset_out, n % 2);
      chk(debug_enable_out, 0);
      tap_reset();
      chk(pulses, n < 2);
    end
    for (int i = 0; i < 6; i++) begin
      a = {1'b1, r[2:0]};
      wr(a, r);
      rd(a, d);
      chk(d, 0);
      chk(debug_enable_out, 0);
    end
    boot(2'h0, 1'b0);
    u_dpac_host_model.burst();
    tick(6);
    rd(`DPAC_ADDR_STATUS, d);
    chk(d[8], 1);
    wr(`DPAC_ADDR_STATUS, 32'h100);
    rd(`DPAC_ADDR_STATUS, d);
    chk(d[8], 0);
    u_dpac_host_model.send(1'b1, 1'b1, {16'h0, KEY}, 32'h0, 16);
    tick(4);
    chk(usb_dm_oe_n_out, 0);
    chk(gpio_used_out, `DPAC_PINS_SWD);
    u_dpac_host_model.send(1'b1, 1'b1, 32'h0, 32'h0, 4);
    tick(4);
    chk(sw_rises, 4);
    wr(`DPAC_ADDR_CTRL, 32'h11);
    tick(2);
    chk(debug_enable_out, 1);
    chk(gpio_used_out, `DPAC_PINS_SWD_SWV);
    chk({tdo_oe_n_out, tdo_out, usb_dm_out}, {1'b0, prev[0], prev[1]});
    rd(`DPAC_ADDR_STATUS, d);
    chk(d[0], 1);
    wr(`DPAC_ADDR_CTRL, 32'h5);
    tick(2);
    chk({scan_access_out, usb_dm_oe_n_out, tms_oe_n_out}, 3'h7);
    wr(`DPAC_ADDR_CTRL, 32'h9);
    tick(2);
    chk({scan_access_out, tms_oe_n_out, gpio_used_out}, 5'h02);
    wr(`DPAC_ADDR_CTRL, 32'hD);
    tick(2);
    chk({ext_access_out, debug_enable_out, gpio_used_out}, 5'h08);
    @(posedge clk_in);
    full_erase_in <= 1'b1;
    @(posedge clk_in);
    full_erase_in <= 1'b0;
    tick(2);
    chk(debug_enable_out, 0);
    boot(2'h0, 1'b1);
    wr(`DPAC_ADDR_CTRL, 32'h1);
    tick(2);
    chk({ext_access_out, debug_enable_out, gpio_used_out}, 0);
    tap_reset();
    chk(pulses, 0);
    conclude();
  end
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
